// ===== inc/qdc_pkg.sv
// ----------------------------------------------------------------------
// Constants and types of the quad converter pin control
// ----------------------------------------------------------------------
package qdc_pkg;

  // Channel and word sizes
  localparam int NUM_CH     = 4;
  localparam int DATA_W     = 14;
  localparam int CAL_W      = 8;
  localparam int GPIO_N     = 2;

  // Serial frame layout: read flag, address, data
  localparam int FRAME_BITS = 24;
  localparam int CNT_W      = 5;
  localparam int RD_BIT     = 23;
  localparam int ADDR_W     = 4;
  localparam int ADDR_LO    = 16;
  localparam int DATA_LO    = 0;

  // Register addresses inside a frame
  localparam logic [ADDR_W-1:0] ADDR_GAIN = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_OFFS = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_GPIO = 4'h6;

  // Reset values; code zero is 0 V in both coding modes
  localparam logic [DATA_W-1:0] CODE_RESET   = 14'h0000;
  localparam logic [DATA_W-1:0] BIPOLAR_FLIP = 14'h2000;
  localparam logic [CAL_W-1:0]  GAIN_RESET   = 8'h00;
  localparam logic [CAL_W-1:0]  OFFS_RESET   = 8'h00;
  localparam logic [GPIO_N-1:0] GPIO_RESET   = 2'h3;

  // Synchronised pin bundle
  typedef struct packed {
    logic              cs_n;
    logic              sclk;
    logic              sdi;
    logic              load_n;
    logic              reset_n;
    logic              pol_a;
    logic              pol_b;
    logic [GPIO_N-1:0] gpio;
  } qdc_pins_t;

  localparam int        SYNC_W    = 9;
  localparam qdc_pins_t SYNC_INIT = 9'h13F;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] qdc_codes_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_DONE  = 3'h4
  } qdc_state_t;

endpackage

// ===== core/qdc_sync.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Two-stage synchroniser for a bundle of pins
// ----------------------------------------------------------------------
module qdc_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Only the second stage is visible outside
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ===== core/qdc_pin_ctrl.sv
`timescale 1ns/100ps
// What this block does
// RQ1: Shift serial bits only while chip select low
// RQ2: Chip select high releases serial output
// RQ3: Load low makes latches copy input registers
// RQ4: Output code changes with latch, no extra stage
// RQ5: Reset pin clears input registers and latches
// RQ6: Reset pin restores gain and offset calibration
// RQ7: General pins only pull low or release
// RQ8: Group A select: high unipolar, low bipolar
// RQ9: Unipolar straight binary, bipolar twos complement
// RQ10: Undriven general pins are sampled as inputs
module qdc_pin_ctrl (
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic                          cs_n,
  input  wire logic                          sclk,
  input  wire logic                          sdi,
  input  wire logic                          load_latch_n,
  input  wire logic                          dev_reset_n,
  input  wire logic                          polarity_select_group_a,
  input  wire logic                          polarity_select_group_b,
  input  wire logic [qdc_pkg::GPIO_N-1:0]    gpio_in,
  output logic                               sdo,
  output logic                               sdo_oe,
  output logic      [qdc_pkg::GPIO_N-1:0]    gpio_out,
  output logic      [qdc_pkg::GPIO_N-1:0]    gpio_oe,
  output logic      [qdc_pkg::GPIO_N-1:0]    gpio_level,
  output qdc_pkg::qdc_codes_t                dac_code,
  output logic      [qdc_pkg::CAL_W-1:0]     gain_cal,
  output logic      [qdc_pkg::CAL_W-1:0]     offset_cal
);
  import qdc_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  qdc_pins_t pins_raw;
  qdc_pins_t pins_s;

  assign pins_raw = {cs_n, sclk, sdi, load_latch_n, dev_reset_n,
                     polarity_select_group_a, polarity_select_group_b,
                     gpio_in};

  qdc_sync #(.W (SYNC_W), .INIT (SYNC_INIT)) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      (pins_raw),
    .q      (pins_s)
  );

  // ----------------------------------------------------------------------
  // Serial edge detection and frame sequencing
  // ----------------------------------------------------------------------
  logic                  sclk_d_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_W-1:0]      cnt_r;
  qdc_state_t            state_r;
  qdc_state_t            state_nxt;
  logic                  sclk_rise;
  logic                  shift_en;
  logic                  frame_ok;
  logic                  frame_rd;
  logic                  frame_wr;
  logic [ADDR_W-1:0]     frame_addr;
  logic [FRAME_BITS-1:0] rd_word;
  logic [15:0]           rd_data;

  // Sampling on the system clock limits sclk to well below clock/4
  assign sclk_rise  = pins_s.sclk & ~sclk_d_r;
  assign shift_en   = sclk_rise & ~pins_s.cs_n; // RQ1
  assign frame_ok   = (state_r == ST_DONE) &&
                      (cnt_r == CNT_W'(FRAME_BITS));
  assign frame_rd   = frame_ok & shift_r[RD_BIT];
  assign frame_wr   = frame_ok & ~shift_r[RD_BIT];
  assign frame_addr = shift_r[ADDR_LO +: ADDR_W];

  // Next state: a frame ends on the rising chip select
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (!pins_s.cs_n) state_nxt = ST_SHIFT;
      ST_SHIFT: if (pins_s.cs_n) state_nxt = ST_DONE;
      ST_DONE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r  <= ST_IDLE;
      sclk_d_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      sclk_d_r <= pins_s.sclk;
    end
  end

  // Bit counter saturates so longer frames keep their last bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (state_r == ST_IDLE) begin
      cnt_r <= '0;
    end else if (shift_en && cnt_r != CNT_W'(FRAME_BITS)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // A read frame reloads the shifter so the next frame returns data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_r <= '0;
    end else if (frame_rd) begin
      shift_r <= rd_word;
    end else if (shift_en) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], pins_s.sdi}; // RQ1
    end
  end

  // Serial output follows the shifter MSB, released when deselected
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= shift_r[FRAME_BITS-1];
      sdo_oe <= ~pins_s.cs_n; // RQ2
    end
  end

  // ----------------------------------------------------------------------
  // Input registers, latches and calibration
  // ----------------------------------------------------------------------
  qdc_codes_t        input_r;
  qdc_codes_t        latch_r;
  qdc_codes_t        code_nxt;
  qdc_codes_t        code_rst;
  logic [CAL_W-1:0]  gain_r;
  logic [CAL_W-1:0]  offs_r;
  logic [GPIO_N-1:0] gpio_ctrl_r;
  logic [NUM_CH-1:0] unipolar;

  // Channels 0 and 1 follow group A, channels 2 and 3 group B
  assign unipolar = {pins_s.pol_b, pins_s.pol_b,
                     pins_s.pol_a, pins_s.pol_a}; // RQ8

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    // Core code is offset binary; twos complement flips the MSB
    assign code_nxt[i] = unipolar[i] ? input_r[i]
                                     : input_r[i] ^ BIPOLAR_FLIP; // RQ9
    assign code_rst[i] = unipolar[i] ? CODE_RESET
                                     : CODE_RESET ^ BIPOLAR_FLIP; // RQ5

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        input_r[i] <= CODE_RESET;
      end else if (!pins_s.reset_n) begin
        input_r[i] <= CODE_RESET; // RQ5
      end else if (frame_wr && frame_addr == ADDR_W'(i)) begin
        input_r[i] <= shift_r[DATA_LO +: DATA_W];
      end
    end

    // Latch and output code move in the same cycle
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        latch_r[i]  <= CODE_RESET;
        dac_code[i] <= CODE_RESET;
      end else if (!pins_s.reset_n) begin
        latch_r[i]  <= CODE_RESET; // RQ5
        dac_code[i] <= code_rst[i]; // RQ5
      end else if (!pins_s.load_n) begin
        latch_r[i]  <= input_r[i]; // RQ3
        dac_code[i] <= code_nxt[i]; // RQ4
      end
    end
  end

  // Calibration registers return to defaults on the reset pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gain_r <= GAIN_RESET;
      offs_r <= OFFS_RESET;
    end else if (!pins_s.reset_n) begin
      gain_r <= GAIN_RESET; // RQ6
      offs_r <= OFFS_RESET; // RQ6
    end else if (frame_wr && frame_addr == ADDR_GAIN) begin
      gain_r <= shift_r[DATA_LO +: CAL_W];
    end else if (frame_wr && frame_addr == ADDR_OFFS) begin
      offs_r <= shift_r[DATA_LO +: CAL_W];
    end
  end

  assign gain_cal   = gain_r;
  assign offset_cal = offs_r;

  // ----------------------------------------------------------------------
  // General-purpose open-drain pins
  // ----------------------------------------------------------------------
  // A zero control bit pulls the pin low; a one releases it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gpio_ctrl_r <= GPIO_RESET;
    end else if (frame_wr && frame_addr == ADDR_GPIO) begin
      gpio_ctrl_r <= shift_r[DATA_LO +: GPIO_N];
    end
  end

  // Output data is always low, so the pin can never drive high
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gpio_out   <= '0;
      gpio_oe    <= '0;
      gpio_level <= GPIO_RESET;
    end else begin
      gpio_out   <= '0; // RQ7
      gpio_oe    <= ~gpio_ctrl_r; // RQ7
      for (int g = 0; g < GPIO_N; g++) begin
        if (!gpio_oe[g]) begin
          gpio_level[g] <= pins_s.gpio[g]; // RQ10
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read-back selection
  // ----------------------------------------------------------------------
  assign rd_data = (frame_addr < ADDR_W'(NUM_CH)) ?
                     16'(input_r[frame_addr[1:0]]) :
                   (frame_addr == ADDR_GAIN) ? 16'(gain_r) :
                   (frame_addr == ADDR_OFFS) ? 16'(offs_r) :
                   (frame_addr == ADDR_GPIO) ? 16'(gpio_level) :
                   16'h0000;
  assign rd_word = {shift_r[FRAME_BITS-1:ADDR_LO], rd_data};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_shift_gate;
    (pins_s.cs_n && state_r != ST_DONE) |=> $stable(shift_r);
  endproperty
  a_shift_gate: assert property (p_shift_gate) // RQ1
    else $error("shifter moved while deselected");
  property p_sdo_release;
    pins_s.cs_n |=> !sdo_oe;
  endproperty
  a_sdo_release: assert property (p_sdo_release) // RQ2
    else $error("serial output driven while deselected");
  property p_load_copy;
    (!pins_s.load_n && pins_s.reset_n) |=> latch_r == $past(input_r);
  endproperty
  a_load_copy: assert property (p_load_copy) // RQ3
    else $error("latch did not copy input register");
  property p_code_hold;
    (pins_s.load_n && pins_s.reset_n) |=> $stable(dac_code);
  endproperty
  a_code_hold: assert property (p_code_hold) // RQ4
    else $error("output code changed without latch update");
  property p_reset_regs;
    !pins_s.reset_n |=> (input_r == '0) && (latch_r == '0) &&
                        (dac_code == $past(code_rst));
  endproperty
  a_reset_regs: assert property (p_reset_regs) // RQ5
    else $error("reset pin did not clear data registers");
  property p_reset_cal;
    !pins_s.reset_n |=> gain_r == GAIN_RESET && offs_r == OFFS_RESET;
  endproperty
  a_reset_cal: assert property (p_reset_cal) // RQ6
    else $error("reset pin did not restore calibration");
  property p_open_drain;
    ##1 (gpio_out == '0) && (gpio_oe == ~$past(gpio_ctrl_r));
  endproperty
  a_open_drain: assert property (p_open_drain) // RQ7
    else $error("general pin not open drain");
  property p_uni_a;
    (!pins_s.load_n && pins_s.reset_n && pins_s.pol_a)
      |=> dac_code[1] == $past(input_r[1]);
  endproperty
  a_uni_a: assert property (p_uni_a) // RQ8
    else $error("group A unipolar code wrong");
  property p_bip_a;
    (!pins_s.load_n && pins_s.reset_n && !pins_s.pol_a)
      |=> dac_code[0] == ($past(input_r[0]) ^ BIPOLAR_FLIP);
  endproperty
  a_bip_a: assert property (p_bip_a) // RQ9
    else $error("group A bipolar code wrong");
  property p_gpio_sample;
    !gpio_oe[0] |=> gpio_level[0] == $past(pins_s.gpio[0]);
  endproperty
  a_gpio_sample: assert property (p_gpio_sample) // RQ10
    else $error("released general pin not sampled");
  c_write: cover property (frame_wr ##[1:20] !pins_s.load_n);
  c_read: cover property (frame_rd ##[1:200] sdo_oe);
  c_reset: cover property (!pins_s.reset_n ##1 pins_s.reset_n);

endmodule

// ===== testbench/qdc_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Serial host model driving the converter's bus pins
// ----------------------------------------------------------------------
module qdc_host_model (
  input  wire logic clock,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  // Idle: select high, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // Select change, then wait out the pin synchronisers
  task automatic cs_set(input logic v);
    cs_n <= v;
    repeat (6) @(posedge clock);
  endtask

  // MSB first; four clocks per phase so the 2FF sampling sees each edge
  // Returned bits are taken as sclk rises, before the block shifts
  task automatic xfer(input logic [23:0] f, output logic [23:0] r);
    for (int i = 23; i >= 0; i--) begin
      sdi <= f[i];
      repeat (4) @(posedge clock);
      r[i] = sdo;
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      sclk <= 1'b0;
    end
    sdi <= ~f[0]; // Stale data is never left on the line
    repeat (4) @(posedge clock);
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import qdc_pkg::*;
  typedef struct packed {
    logic [3:0]        sel;
    logic [DATA_W-1:0] val;
  } qdc_note_t;

  logic              clock, resetn, load_latch_n, dev_reset_n, chk;
  logic              pol_a, pol_b, cs_n, sclk, sdi, sdo, sdo_oe;
  logic [GPIO_N-1:0] gpio_out, gpio_oe, gpio_level, gpio_ext, gpio_in;
  logic [CAL_W-1:0]  gain_cal, offset_cal;
  logic [23:0]       rd_cap;
  logic              sdo_line;
  logic [DATA_W-1:0] code_r [NUM_CH];
  qdc_codes_t        dac_code;
  qdc_note_t         notes [$];
  int                n_fail, cmp_count;

  // Open-drain wire: pull-up, outside party or the block may pull low
  assign gpio_in = gpio_ext & ~gpio_oe;
  // A released serial line shows the opposite of its last bit
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  qdc_host_model qdc_host_model_i (
    .clock (clock),
    .sdo   (sdo_line),
    .cs_n  (cs_n),
    .sclk  (sclk),
    .sdi   (sdi)
  );

  qdc_pin_ctrl qdc_pin_ctrl_i (
    .clock                   (clock),
    .resetn                  (resetn),
    .cs_n                    (cs_n),
    .sclk                    (sclk),
    .sdi                     (sdi),
    .load_latch_n            (load_latch_n),
    .dev_reset_n             (dev_reset_n),
    .polarity_select_group_a (pol_a),
    .polarity_select_group_b (pol_b),
    .gpio_in                 (gpio_in),
    .sdo                     (sdo),
    .sdo_oe                  (sdo_oe),
    .gpio_out                (gpio_out),
    .gpio_oe                 (gpio_oe),
    .gpio_level              (gpio_level),
    .dac_code                (dac_code),
    .gain_cal                (gain_cal),
    .offset_cal              (offset_cal)
  );

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // Output selected by a note
  function automatic logic [DATA_W-1:0] obs(input logic [3:0] s);
    case (s)
      4'h4:    obs = DATA_W'(gain_cal);
      4'h5:    obs = DATA_W'(offset_cal);
      4'h6:    obs = DATA_W'(gpio_oe);
      4'h7:    obs = DATA_W'(gpio_out);
      4'h8:    obs = DATA_W'(gpio_level);
      4'h9:    obs = DATA_W'(sdo_oe);
      4'hA:    obs = rd_cap[DATA_W-1:0];
      4'hB:    obs = DATA_W'(rd_cap[23:14]);
      default: obs = dac_code[s[1:0]];
    endcase
  endfunction

  // Note an expectation; the watcher compares it on the next edge
  task automatic note_exp(input logic [3:0] s, input logic [DATA_W-1:0] v);
    notes.push_back('{s, v});
    chk <= 1'b1;
    @(posedge clock);
    chk <= 1'b0;
    @(posedge clock);
  endtask

  // Watcher takes the oldest note off the queue
  always @(posedge clock) begin
    if (chk) begin
      check(obs(notes[0].sel), notes[0].val);
      void'(notes.pop_front());
    end
  end

  task automatic print_verdict();
    $display("failures %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  // One selected frame; the bits seen on the serial output land in rd_cap
  task automatic frame(input logic [23:0] f);
    qdc_host_model_i.cs_set(1'b0);
    note_exp(4'h9, 14'h0001);
    qdc_host_model_i.xfer(f, rd_cap);
    qdc_host_model_i.cs_set(1'b1);
    note_exp(4'h9, 14'h0000);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    frame({4'h0, a, d});
  endtask

  // Strobe low for six clocks; the caller releases it
  task automatic pulse(input bit rst);
    if (rst) begin
      dev_reset_n <= 1'b0;
    end else begin
      load_latch_n <= 1'b0;
    end
    repeat (6) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // A hang counts as a failure
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end

  initial begin
    logic [DATA_W-1:0] v0;
    resetn       = 1'b0;
    load_latch_n = 1'b1;
    dev_reset_n  = 1'b1;
    pol_a        = 1'b1;
    pol_b        = 1'b0;
    chk          = 1'b0;
    gpio_ext     = 2'h3;
    n_fail       = 0;
    cmp_count    = 0;
    void'($urandom(32'hd6ab));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    note_exp(4'h6, 14'h0000);
    // Both polarity settings, groups opposite, every channel
    for (int p = 0; p < 2; p++) begin
      pol_a <= p[0];
      pol_b <= ~p[0];
      for (int c = 0; c < NUM_CH; c++) begin
        code_r[c] = DATA_W'($urandom);
        wr_reg(c[3:0], {{2{code_r[c][13]}}, code_r[c]});
      end
      pulse(1'b0);
      load_latch_n <= 1'b1;
      repeat (4) @(posedge clock);
      for (int c = 0; c < NUM_CH; c++) begin
        note_exp(c[3:0], code_r[c] ^ (((c < 2) ? p[0] : ~p[0]) ?
                 14'h0000 : BIPOLAR_FLIP));
      end
    end
    // Latch holds until load; a frame with select high is ignored
    v0 = DATA_W'($urandom);
    wr_reg(4'h0, {2'b00, v0});
    qdc_host_model_i.xfer({8'h01, 2'b00, ~code_r[1]}, rd_cap);
    note_exp(4'h0, code_r[0]);
    pulse(1'b0);
    note_exp(4'h0, v0);
    note_exp(4'h1, code_r[1]);
    load_latch_n <= 1'b1;
    // Calibration and device reset
    wr_reg(4'h4, 16'h005A);
    wr_reg(4'h5, 16'h00A5);
    note_exp(4'h4, 14'h005A);
    note_exp(4'h5, 14'h00A5);
    // Read offset back: a read frame, then a frame that clocks it out
    frame(24'h85_0000);
    frame(24'h8F_0000);
    note_exp(4'hA, 14'h00A5);
    note_exp(4'hB, 14'h0214);
    pulse(1'b1);
    note_exp(4'h0, CODE_RESET);
    note_exp(4'h3, CODE_RESET ^ BIPOLAR_FLIP);
    note_exp(4'h4, 14'(GAIN_RESET));
    note_exp(4'h5, 14'(OFFS_RESET));
    dev_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // General pins: pin 1 pulled low, pin 0 released and sampled
    wr_reg(4'h6, 16'h0001);
    note_exp(4'h6, 14'h0002);
    note_exp(4'h7, 14'h0000);
    for (int k = 0; k < 4; k++) begin
      gpio_ext <= 2'($urandom);
      repeat (5) @(posedge clock);
      // Pin 1 is pulled low, so its level holds the last released value
      note_exp(4'h8, 14'({1'b1, gpio_ext[0]}));
    end
    frame(24'h86_0000);
    frame(24'h8F_0000);
    note_exp(4'hA, 14'({1'b1, gpio_ext[0]}));
    print_verdict();
  end
endmodule
